// ---- src/wdtwk_top.sv ----
// watchdog timer with halt, wake-up and reset flag logic
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: watchdog counts low-speed oscillator ticks divided by power of two
// RULE2: timeout_select codes pick exponents 8,10,12,14,15,16,17,18
// RULE3: key 10101 disables, 01010 enables, others reset after delay
// RULE4: invalid key reset sets wdt_key_reset_flag
// RULE5: hardware only sets wdt_key_reset_flag; software clears it
// RULE6: enable key is 01010 after power-on
// RULE7: overflow in run mode resets device and sets timeout flag
// RULE8: overflow while halted sets timeout flag, wakes, resets pc and sp only
// RULE9: counter cleared by bad key, clear instruction or halt
// RULE10: halt enters sleep or idle and sets power-down flag
// RULE11: power-up or clear instruction clears power-down flag
// RULE12: halted device wakes on port edge, interrupt or overflow
// RULE13: per-pin port wake enables; port wake resumes after halt
// RULE14: disabled interrupt or full stack: resume after halt, keep pending
// RULE15: enabled interrupt with stack room is serviced at wake
// RULE16: interrupts pending before halt are not wake sources
// RULE17: halt clears counter; counting continues only when enabled
// RULE18: halt clears timeout flag while setting power-down flag
// RULE19: 18-bit up counter; overflow when selected bit rolls over
module wdtwk_top
  import wdtwk_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire wdtwk_req_t bus_req,
  output logic [7:0] bus_rdata,
  // core side
  input wire logic low_speed_internal_osc_tick,
  input wire logic halt_exec,
  input wire logic clear_watchdog_instruction,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] irq_request,
  input wire logic [7:0] irq_enable,
  input wire logic stack_full,
  output logic halted,
  output logic wake_pulse,
  output logic wake_service_irq,
  output logic pc_sp_reset,
  output logic device_reset,
  output logic irq
);
  logic [7:0] control_reg;
  logic wdt_key_reset_flag_reg;
  logic power_down_flag_reg;
  logic timeout_status_flag_reg;
  logic [7:0] port_wake_enable_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [CTR_W-1:0] count_reg;
  logic [7:0] port_prev_reg;
  logic [7:0] irq_armed_reg;
  logic [15:0] delay_reg;
  wdtwk_state_t state_reg;
  logic halted_reg, wake_reg, svc_reg, pcsp_reg, devrst_reg, irq_reg;
  logic [7:0] rdata_reg;

  // exponent table, used for overflow bit select
  function automatic logic [4:0] sel_exp(input logic [2:0] s);
    case (s)
      3'h0: sel_exp = 5'h08;
      3'h1: sel_exp = 5'h0A;
      3'h2: sel_exp = 5'h0C;
      3'h3: sel_exp = 5'h0E;
      3'h4: sel_exp = 5'h0F;
      3'h5: sel_exp = 5'h10;
      3'h6: sel_exp = 5'h11;
      default: sel_exp = 5'h12;
    endcase
  endfunction

  function automatic logic key_bad(input logic [4:0] k);
    key_bad = (k != KEY_ENABLE) && (k != KEY_DISABLE);
  endfunction

  logic [4:0] key;
  logic wdt_on;
  logic ctl_wr;
  logic bad_key_wr;
  logic overflow;
  logic [4:0] ovf_exp;
  logic [CTR_W:0] count_ext;
  logic [CTR_W:0] ovf_mask;
  logic port_wake;
  logic irq_wake;
  logic any_wake;
  logic svc_now;

  assign key = control_reg[7:KEY_LSB];
  assign wdt_on = (key == KEY_ENABLE);
  assign ctl_wr = bus_req.wr && (bus_req.addr == ADDR_CONTROL);
  assign bad_key_wr = ctl_wr && key_bad(bus_req.wdata[7:KEY_LSB]);
  assign ovf_exp = sel_exp(control_reg[2:0]); // see RULE2
  assign count_ext = {1'b0, count_reg};
  // all bits below the selected exponent set: this tick rolls the selected bit over
  // mask one bit wider than the counter so an exponent of 18 still fits
  assign ovf_mask = (19'h00001 << ovf_exp) - 19'h00001;
  assign overflow = wdt_on && low_speed_internal_osc_tick &&
                    ((count_ext & ovf_mask) == ovf_mask); // see RULE19
  assign port_wake = |(port_prev_reg & ~port_a_pins & port_wake_enable_reg); // see RULE13
  assign irq_wake = |(irq_request & irq_armed_reg); // see RULE16
  assign any_wake = port_wake || irq_wake || overflow; // see RULE12
  assign svc_now = |(irq_request & irq_armed_reg & irq_enable) && !stack_full; // see RULE15

  // watchdog counter
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= '0;
    end else if (bad_key_wr || clear_watchdog_instruction ||
                 (halt_exec && state_reg == WDTWK_RUN)) begin
      count_reg <= '0; // see RULE9 see RULE17
    end else if (overflow) begin
      count_reg <= '0;
    end else if (wdt_on && low_speed_internal_osc_tick) begin
      count_reg <= count_reg + 18'h00001; // see RULE1 see RULE19
    end
  end

  // control register and key reset flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      control_reg <= CONTROL_RESET; // see RULE6
      wdt_key_reset_flag_reg <= 1'b0;
      port_wake_enable_reg <= 8'h00;
      irq_mask_reg <= 3'h0;
    end else begin
      if (ctl_wr) begin
        control_reg <= bus_req.wdata;
      end
      if (bus_req.wr && bus_req.addr == ADDR_WAKE_EN) begin
        port_wake_enable_reg <= bus_req.wdata;
      end
      if (bus_req.wr && bus_req.addr == ADDR_IRQ_MASK) begin
        irq_mask_reg <= bus_req.wdata[2:0];
      end
      // set wins over a software clear in the same cycle
      if (bad_key_wr) begin
        wdt_key_reset_flag_reg <= 1'b1; // see RULE4 see RULE5
      end else if (bus_req.wr && bus_req.addr == ADDR_CAUSE &&
                   !bus_req.wdata[CAUSE_WDT_KEY_BIT]) begin
        wdt_key_reset_flag_reg <= 1'b0; // see RULE5
      end
    end
  end

  // state machine: run, halted, waiting for soft reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= WDTWK_RUN;
      delay_reg <= 16'h0000;
      irq_armed_reg <= 8'h00;
    end else begin
      case (state_reg)
        WDTWK_RUN: begin
          if (bad_key_wr) begin
            state_reg <= WDTWK_RSTWAIT; // see RULE3
            delay_reg <= 16'(SOFT_RESET_CYCLES - 1);
          end else if (halt_exec) begin
            state_reg <= WDTWK_HALTED; // see RULE10
            irq_armed_reg <= ~irq_request; // see RULE16
          end
        end
        WDTWK_HALTED: begin
          if (bad_key_wr) begin
            state_reg <= WDTWK_RSTWAIT;
            delay_reg <= 16'(SOFT_RESET_CYCLES - 1);
          end else if (any_wake) begin
            state_reg <= WDTWK_RUN; // see RULE12 see RULE14
          end
        end
        WDTWK_RSTWAIT: begin
          if (delay_reg == 16'h0000) begin
            state_reg <= WDTWK_RUN;
          end else begin
            delay_reg <= delay_reg - 16'h0001;
          end
        end
        default: state_reg <= WDTWK_RUN;
      endcase
    end
  end

  // power-down and timeout flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_down_flag_reg <= 1'b0; // see RULE11
      timeout_status_flag_reg <= 1'b0;
    end else begin
      if (overflow) begin
        timeout_status_flag_reg <= 1'b1; // see RULE7 see RULE8
      end else if (halt_exec && state_reg == WDTWK_RUN) begin
        timeout_status_flag_reg <= 1'b0; // see RULE18
      end
      if (halt_exec && state_reg == WDTWK_RUN) begin
        power_down_flag_reg <= 1'b1; // see RULE10 see RULE18
      end else if (clear_watchdog_instruction) begin
        power_down_flag_reg <= 1'b0; // see RULE11
      end
    end
  end

  // port edge history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_prev_reg <= 8'hFF;
    end else begin
      port_prev_reg <= port_a_pins;
    end
  end

  // core-facing outputs, all registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      halted_reg <= 1'b0;
      wake_reg <= 1'b0;
      svc_reg <= 1'b0;
      pcsp_reg <= 1'b0;
      devrst_reg <= 1'b0;
    end else begin
      halted_reg <= (state_reg == WDTWK_HALTED && !any_wake && !bad_key_wr) ||
                    (state_reg == WDTWK_RUN && halt_exec && !bad_key_wr);
      wake_reg <= (state_reg == WDTWK_HALTED) && any_wake && !bad_key_wr;
      // pending but unserviceable requests stay with the core
      svc_reg <= (state_reg == WDTWK_HALTED) && !overflow && svc_now; // see RULE14 see RULE15
      pcsp_reg <= (state_reg == WDTWK_HALTED) && overflow; // see RULE8
      devrst_reg <= ((state_reg == WDTWK_RUN) && overflow) || // see RULE7
                    ((state_reg == WDTWK_RSTWAIT) && delay_reg == 16'h0000); // see RULE3
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_stat_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if ((i == IRQ_OVF_BIT && overflow) || (i == IRQ_KEYRST_BIT && bad_key_wr) ||
            (i == IRQ_WAKE_BIT && state_reg == WDTWK_HALTED && any_wake)) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (bus_req.wr && bus_req.addr == ADDR_IRQ_STAT && bus_req.wdata[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CONTROL: rdata_reg <= control_reg;
        ADDR_CAUSE: rdata_reg <= {7'h00, wdt_key_reset_flag_reg};
        ADDR_STATUS: rdata_reg <= {6'h00, timeout_status_flag_reg, power_down_flag_reg};
        ADDR_WAKE_EN: rdata_reg <= port_wake_enable_reg;
        ADDR_IRQ_STAT: rdata_reg <= {5'h00, irq_stat_reg};
        ADDR_IRQ_MASK: rdata_reg <= {5'h00, irq_mask_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign bus_rdata = rdata_reg;
  assign halted = halted_reg;
  assign wake_pulse = wake_reg;
  assign wake_service_irq = svc_reg;
  assign pc_sp_reset = pcsp_reg;
  assign device_reset = devrst_reg;
  assign irq = irq_reg;

  // assertions
  property p_halt_flags;
    @(posedge clk) disable iff (reset)
    (halt_exec && state_reg == WDTWK_RUN && !overflow) |=>
      (power_down_flag_reg && !timeout_status_flag_reg);
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong"); // see RULE18

  property p_clr_pdf;
    @(posedge clk) disable iff (reset)
    (clear_watchdog_instruction && !halt_exec) |=> !power_down_flag_reg;
  endproperty
  a_clr_pdf: assert property (p_clr_pdf) else $error("pdf not cleared"); // see RULE11

  property p_key_flag;
    @(posedge clk) disable iff (reset)
    bad_key_wr |=> wdt_key_reset_flag_reg;
  endproperty
  a_key_flag: assert property (p_key_flag) else $error("key flag not set"); // see RULE4

  property p_flag_sticky;
    @(posedge clk) disable iff (reset)
    (wdt_key_reset_flag_reg && !(bus_req.wr && bus_req.addr == ADDR_CAUSE)) |=>
      wdt_key_reset_flag_reg;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("key flag lost"); // see RULE5

  property p_clear_ctr;
    @(posedge clk) disable iff (reset)
    clear_watchdog_instruction |=> (count_reg == '0);
  endproperty
  a_clear_ctr: assert property (p_clear_ctr) else $error("counter not cleared"); // see RULE9

  property p_run_ovf;
    @(posedge clk) disable iff (reset)
    (overflow && state_reg == WDTWK_RUN) |=> (device_reset && timeout_status_flag_reg);
  endproperty
  a_run_ovf: assert property (p_run_ovf) else $error("no reset on overflow"); // see RULE7

  property p_halt_ovf;
    @(posedge clk) disable iff (reset)
    (overflow && state_reg == WDTWK_HALTED && !bad_key_wr) |=>
      (pc_sp_reset && wake_pulse && !device_reset);
  endproperty
  a_halt_ovf: assert property (p_halt_ovf) else $error("halted overflow wrong"); // see RULE8

  sequence s_bad_key;
    bad_key_wr && state_reg != WDTWK_RSTWAIT;
  endsequence
  property p_soft_reset;
    @(posedge clk) disable iff (reset)
    s_bad_key |-> ##[1:500] device_reset;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("no soft reset"); // see RULE3

  property p_disabled_stop;
    @(posedge clk) disable iff (reset)
    (!wdt_on && !ctl_wr) |=> (count_reg == $past(count_reg) || count_reg == '0);
  endproperty
  a_disabled_stop: assert property (p_disabled_stop) else $error("counts when off"); // see RULE17

  sequence s_halt_taken;
    halt_exec && state_reg == WDTWK_RUN && !bad_key_wr;
  endsequence
  property p_halt_enter;
    @(posedge clk) disable iff (reset)
    s_halt_taken |=> halted;
  endproperty
  a_halt_enter: assert property (p_halt_enter) else $error("halt not entered"); // see RULE10

  property p_halt_clr_ctr;
    @(posedge clk) disable iff (reset)
    s_halt_taken |=> (count_reg == '0);
  endproperty
  a_halt_clr_ctr: assert property (p_halt_clr_ctr) else $error("halt kept count"); // see RULE17

  property p_port_wake;
    @(posedge clk) disable iff (reset)
    (state_reg == WDTWK_HALTED && port_wake && !bad_key_wr) |=>
      (wake_pulse && !halted);
  endproperty
  a_port_wake: assert property (p_port_wake) else $error("no port wake"); // see RULE13

  property p_svc_wake;
    @(posedge clk) disable iff (reset)
    (state_reg == WDTWK_HALTED && svc_now && !overflow && !bad_key_wr) |=>
      (wake_service_irq && wake_pulse);
  endproperty
  a_svc_wake: assert property (p_svc_wake) else $error("no service at wake"); // see RULE15

  property p_full_no_svc;
    @(posedge clk) disable iff (reset)
    stack_full |=> !wake_service_irq;
  endproperty
  a_full_no_svc: assert property (p_full_no_svc) else $error("serviced when full"); // see RULE14
endmodule
`default_nettype wire

// ---- common/wdtwk_pkg.sv ----
// package for the watchdog and wake-up control block
package wdtwk_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_CAUSE = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_WAKE_EN = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  // reset value and key codes
  localparam logic [7:0] CONTROL_RESET = 8'h53;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [4:0] KEY_ENABLE = 5'h0A;
  // field positions
  localparam int KEY_LSB = 3;
  localparam int CAUSE_WDT_KEY_BIT = 0;
  localparam int STATUS_PDF_BIT = 0;
  localparam int STATUS_TO_BIT = 1;
  // interrupt status bits
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_KEYRST_BIT = 1;
  localparam int IRQ_WAKE_BIT = 2;
  localparam int CTR_W = 18;
  // timing: system clock and soft reset delay
  localparam int CLK_HZ = 25000000;
  localparam int SOFT_RESET_DELAY_US = 16;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_DELAY_US * (CLK_HZ / 1000000));
  typedef enum logic [2:0] {
    WDTWK_RUN = 3'b001,
    WDTWK_HALTED = 3'b010,
    WDTWK_RSTWAIT = 3'b100
  } wdtwk_state_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wdtwk_req_t;
endpackage

// ---- dv/wdtwk_core_model.sv ----
// core model: oscillator ticks, halt and clear instructions
`timescale 1ns/1ps
`default_nettype none
module wdtwk_core_model #(
  parameter int TICK_DIV = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // core side
  output logic low_speed_internal_osc_tick,
  output logic halt_exec,
  output logic clear_watchdog_instruction
);
  int div;
  // fast oscillator so the shortest timeouts fit the run
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div <= 0;
      low_speed_internal_osc_tick <= 1'b0;
    end else begin
      div <= (div == TICK_DIV - 1) ? 0 : div + 1;
      low_speed_internal_osc_tick <= (div == TICK_DIV - 1);
    end
  end
  initial begin
    halt_exec = 1'b0;
    clear_watchdog_instruction = 1'b0;
  end
  task automatic pulse(input bit is_halt);
    @(posedge clk);
    if (is_halt) halt_exec <= 1'b1;
    else clear_watchdog_instruction <= 1'b1;
    @(posedge clk);
    halt_exec <= 1'b0;
    clear_watchdog_instruction <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- dv/test_wdtwk_top.sv ----
// self-checking bench for the watchdog and wake-up block
`timescale 1ns/1ps
`default_nettype none
module test_wdtwk_top;
  import wdtwk_pkg::*;
  localparam int P = 4;
  int ex[8] = '{8, 10, 12, 14, 15, 16, 17, 18};
  logic clk = 1'b0;
  logic reset = 1'b1;
  wdtwk_req_t bus_req;
  logic [7:0] bus_rdata, d, port_a_pins, irq_request, irq_enable;
  logic stack_full;
  logic tick, halt_exec, clr, halted, wake_pulse, wake_srv, pc_sp_reset, device_reset, irq;
  int n_fail = 0;
  int total_checks = 0;
  int n, lim;
  longint t0;
  always #20 clk = ~clk;
  wdtwk_core_model #(.TICK_DIV(P)) u_core (.clk(clk), .reset(reset), .low_speed_internal_osc_tick(tick),
    .halt_exec(halt_exec), .clear_watchdog_instruction(clr));
  wdtwk_top u_dut (.clk(clk), .reset(reset), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .low_speed_internal_osc_tick(tick), .halt_exec(halt_exec), .clear_watchdog_instruction(clr),
    .port_a_pins(port_a_pins), .irq_request(irq_request), .irq_enable(irq_enable),
    .stack_full(stack_full), .halted(halted), .wake_pulse(wake_pulse),
    .wake_service_irq(wake_srv), .pc_sp_reset(pc_sp_reset), .device_reset(device_reset),
    .irq(irq));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // oscillator ticks in one timeout period for a select code
  function automatic int ticks(input int c);
    return 1 << ex[c];
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 check(what, bus_rdata, exp);
  endtask
  // cycles until the chosen pulse; lim+1 when it never came
  task automatic wait_for(input int sel, input int lim, input bit must, output int cnt);
    logic s;
    cnt = 0;
    do begin
      @(posedge clk);
      #1 cnt++;
      s = (sel == 0) ? device_reset : (sel == 1) ? wake_pulse : pc_sp_reset;
    end while (s !== 1'b1 && cnt <= lim);
    if (must && cnt > lim) begin
      n_fail++;
      $display("CHECK FAILED pulse %0d expected 1 seen 0", sel);
      results();
    end
  endtask
  task automatic sys_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
  endtask
  initial begin
    void'($urandom(32'h561812AF));
    bus_req <= '0;
    port_a_pins <= 8'hFF;
    irq_request <= 8'h00;
    irq_enable <= 8'h00;
    stack_full <= 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rchk("control", ADDR_CONTROL, CONTROL_RESET);
    rchk("cause", ADDR_CAUSE, 8'h00);
    rchk("status", ADDR_STATUS, 8'h00);
    rchk("unmapped", 4'hF, 8'h00);
    $display("test timeout select");
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CONTROL, {KEY_ENABLE, 3'(c)});
      rchk("select", ADDR_CONTROL, {KEY_ENABLE, 3'(c)});
    end
    // only the three shortest periods fit the run length
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_CONTROL, {KEY_ENABLE, 3'(c)});
      u_core.pulse(1'b0);
      wait_for(0, ticks(c) * P + 8, 1'b1, n);
      check("period", n >= (ticks(c) - 1) * P, 1);
      rchk("timeout flag", ADDR_STATUS, 8'h02);
      sys_reset();
    end
    $display("test disable and clear");
    wr(ADDR_CONTROL, {KEY_DISABLE, 3'h0});
    wait_for(0, 3000, 1'b0, n);
    check("disabled", n, 3001);
    wr(ADDR_CONTROL, {KEY_ENABLE, 3'h0});
    repeat (6) begin
      u_core.pulse(1'b0);
      lim = 300 + $urandom_range(500);
      wait_for(0, lim, 1'b0, n);
      check("cleared", n, lim + 1);
    end
    $display("test halt and wake");
    wr(ADDR_CONTROL, {KEY_DISABLE, 3'h0});
    d = 8'(1 << $urandom_range(7));
    wr(ADDR_WAKE_EN, d);
    u_core.pulse(1'b1);
    #1 check("halted", halted, 1'b1);
    rchk("pdf", ADDR_STATUS, 8'h01);
    @(posedge clk);
    port_a_pins <= d;
    wait_for(1, 20, 1'b0, n);
    check("disabled pin", n, 21);
    @(posedge clk);
    port_a_pins <= 8'h00;
    wait_for(1, 20, 1'b1, n);
    check("port wake", {halted, wake_srv}, 2'b00);
    port_a_pins <= 8'hFF;
    u_core.pulse(1'b0);
    rchk("pdf clear", ADDR_STATUS, 8'h00);
    for (int i = 0; i < 3; i++) begin
      u_core.pulse(1'b1);
      @(posedge clk);
      irq_enable <= (i == 1) ? 8'h00 : 8'hFF;
      stack_full <= (i == 2);
      irq_request <= 8'(1 << $urandom_range(7));
      wait_for(1, 20, 1'b1, n);
      check("service", wake_srv, i == 0);
      check("resume", halted, 1'b0);
      irq_request <= 8'h00;
    end
    irq_request <= 8'h04;
    u_core.pulse(1'b1);
    wait_for(1, 30, 1'b0, n);
    check("pending", n, 31);
    port_a_pins <= 8'h00;
    wait_for(1, 20, 1'b1, n);
    port_a_pins <= 8'hFF;
    irq_request <= 8'h00;
    $display("test overflow while halted");
    wr(ADDR_CONTROL, {KEY_ENABLE, 3'h0});
    u_core.pulse(1'b1);
    wait_for(2, 256 * P + 8, 1'b1, n);
    check("halt period", n >= 255 * P, 1);
    check("no reset", device_reset, 1'b0);
    rchk("halt timeout", ADDR_STATUS, 8'h03);
    $display("test bad key");
    wr(ADDR_CONTROL, {KEY_DISABLE, 3'h0});
    wr(ADDR_IRQ_MASK, 8'h00);
    wr(ADDR_IRQ_STAT, 8'hFF);
    do d = 8'($urandom); while (d[7:3] == KEY_ENABLE || d[7:3] == KEY_DISABLE);
    wr(ADDR_CONTROL, d);
    t0 = $time;
    rchk("key flag", ADDR_CAUSE, 8'h01);
    rchk("irq status", ADDR_IRQ_STAT, 8'h02);
    check("irq masked", irq, 1'b0);
    wr(ADDR_IRQ_MASK, 8'hFF);
    repeat (2) @(posedge clk);
    #1 check("irq on", irq, 1'b1);
    wait_for(0, SOFT_RESET_CYCLES + 2, 1'b1, n);
    check("delay", 32'(($time - t0) / 40), SOFT_RESET_CYCLES);
    rchk("flag kept", ADDR_CAUSE, 8'h01);
    wr(ADDR_CAUSE, 8'h00);
    rchk("flag cleared", ADDR_CAUSE, 8'h00);
    results();
  end
endmodule
`default_nettype wire
